// [logic/cms_selector.sv]
// Commutation method selector: configuration register, zero-crossing
// versus integration decision and back-EMF integration commutation.
// Assumes all data inputs come from logic on the same clock.
`timescale 1ns/1ps
`include "cms_defs.svh"

module cms_selector #(
   parameter int BEMF_W = 12,
   parameter int ACC_W  = 16
) (
   // Clock, reset, enable
   input  wire logic                clock,
   input  wire logic                rst_n,
   input  wire logic                ce,
   // Configuration write and readback
   input  wire logic                cfg_wr,
   input  wire logic [7:0]          cfg_addr,
   input  wire logic [31:0]         cfg_wdata,
   output logic      [31:0]         cfg_rdata,
   // Measures from sampler and duty generator
   input  wire logic                scnt_valid,
   input  wire logic [7:0]          scnt,
   input  wire logic [6:0]          duty_pct,
   // Floating-phase back-EMF
   input  wire logic                zero_point,
   input  wire logic                phase_falling,
   input  wire logic                bemf_valid,
   input  wire logic [BEMF_W-1:0]   bemf_mag,
   // Results to sequencer
   output logic                     integ_mode,
   output logic                     commute,
   output logic      [11:0]         falling_phase_limit,
   output logic      [11:0]         rising_phase_limit
);
   import cms_pkg::*;

   typedef struct packed {
      cms_mode_t         mode;
      logic [31:0]       cfg;
      logic [ACC_W-1:0]  acc;
      logic              integ;
      logic              commute;
      logic [11:0]       fall_thr;
      logic [11:0]       rise_thr;
   } cms_state_t;

   localparam cms_state_t CMS_RESET_STATE = '{
      mode: CMS_ZERO_CROSSING, cfg: `CMS_CFG3_RESET, acc: '0,
      integ: 1'b0, commute: 1'b0, fall_thr: 12'h000, rise_thr: 12'h000};

   logic [1:0]  rst_sync_r;
   logic        rst_int_n;
   cms_state_t  st_r;
   cms_state_t  st_nxt;

   // Piecewise-linear threshold decode
   function automatic logic [11:0] cms_thr_decode(input logic [5:0] code);
      logic [11:0] c;
      c = {6'h00, code};
      if (code < `CMS_THR_SEG1)
         cms_thr_decode = 12'(c * `CMS_THR_STEP0);
      else if (code < `CMS_THR_SEG2)
         cms_thr_decode = 12'(`CMS_THR_BASE1 + (c - {6'h00, `CMS_THR_SEG1}) * `CMS_THR_STEP1);
      else if (code < `CMS_THR_SEG3)
         cms_thr_decode = 12'(`CMS_THR_BASE2 + (c - {6'h00, `CMS_THR_SEG2}) * `CMS_THR_STEP2);
      else
         cms_thr_decode = 12'(`CMS_THR_BASE3 + (c - {6'h00, `CMS_THR_SEG3}) * `CMS_THR_STEP3);
   endfunction

   // Reset release through two flops so removal is clock aligned
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         rst_sync_r <= 2'h0;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_int_n = rst_sync_r[1];

   // Limits decoded from the live configuration word; slope threshold from the registered decode
   logic [7:0]  su_lim;
   logic [7:0]  sl_lim;
   logic [6:0]  du_lim;
   logic [6:0]  dl_lim;
   logic [11:0] slope_thr;
   always_comb
   begin
      unique case (st_r.cfg[`CMS_SCNT_UP_HI:`CMS_SCNT_UP_LO])
         2'h0: su_lim = `CMS_SU_0;
         2'h1: su_lim = `CMS_SU_1;
         2'h2: su_lim = `CMS_SU_2;
         2'h3: su_lim = `CMS_SU_3;
      endcase
      unique case (st_r.cfg[`CMS_SCNT_LO_HI:`CMS_SCNT_LO_LO])
         2'h0: sl_lim = `CMS_SL_0;
         2'h1: sl_lim = `CMS_SL_1;
         2'h2: sl_lim = `CMS_SL_2;
         2'h3: sl_lim = `CMS_SL_3;
      endcase
      unique case (st_r.cfg[`CMS_DUTY_UP_HI:`CMS_DUTY_UP_LO])
         2'h0: du_lim = `CMS_DUTY_0;
         2'h1: du_lim = `CMS_DUTY_1;
         2'h2: du_lim = `CMS_DUTY_2;
         2'h3: du_lim = `CMS_DUTY_3;
      endcase
      unique case (st_r.cfg[`CMS_DUTY_LO_HI:`CMS_DUTY_LO_LO])
         2'h0: dl_lim = `CMS_DUTY_0;
         2'h1: dl_lim = `CMS_DUTY_1;
         2'h2: dl_lim = `CMS_DUTY_2;
         2'h3: dl_lim = `CMS_DUTY_3;
      endcase
      slope_thr = phase_falling ? st_r.fall_thr : st_r.rise_thr;
   end

   // Next-state logic; ce low holds every field
   always_comb
   begin
      logic                 go_integ;
      logic                 go_zc;
      logic [ACC_W:0]       sum;
      go_integ = 1'b0;
      go_zc    = 1'b0;
      sum      = '0;
      st_nxt   = st_r;
      if (ce)
      begin
         st_nxt.commute = 1'b0;
         // Register write; decoded thresholds follow one cycle later
         if (cfg_wr && cfg_addr == `CMS_CFG3_ADDR)
            st_nxt.cfg = cfg_wdata;
         st_nxt.fall_thr = cms_thr_decode(st_r.cfg[`CMS_FALL_HI:`CMS_FALL_LO]);
         st_nxt.rise_thr = cms_thr_decode(st_r.cfg[`CMS_RISE_HI:`CMS_RISE_LO]);
         go_integ = (scnt_valid && scnt > su_lim) || (duty_pct > du_lim);
         go_zc = (scnt_valid && scnt < sl_lim) || (duty_pct < dl_lim);
         sum = {1'b0, st_r.acc} + (ACC_W+1)'(bemf_mag);
         unique case (st_r.mode)
            CMS_ZERO_CROSSING:
            begin
               if (go_integ)
               begin
                  st_nxt.mode  = CMS_INTEG_WAIT;
                  st_nxt.integ = 1'b1;
               end
            end
            CMS_INTEG_WAIT, CMS_INTEG_ACC:
            begin
               if (go_zc)
               begin
                  st_nxt.mode  = CMS_ZERO_CROSSING;
                  st_nxt.integ = 1'b0;
                  st_nxt.acc   = '0;
               end
               else if (zero_point)
               begin
                  st_nxt.mode = CMS_INTEG_ACC;
                  st_nxt.acc  = '0;
               end
               else if (st_r.mode == CMS_INTEG_ACC && bemf_valid)
               begin
                  if (sum >= (ACC_W+1)'(slope_thr))
                  begin
                     st_nxt.commute = 1'b1;
                     st_nxt.mode    = CMS_INTEG_WAIT;
                     st_nxt.acc     = '0;
                  end
                  else
                     st_nxt.acc = sum[ACC_W] ? '1 : sum[ACC_W-1:0];
               end
            end
            default:
            begin
               st_nxt.mode  = CMS_ZERO_CROSSING;
               st_nxt.integ = 1'b0;
               st_nxt.acc   = '0;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clock or negedge rst_int_n)
   begin
      if (!rst_int_n)
         st_r <= CMS_RESET_STATE;
      else
         st_r <= st_nxt;
   end

   assign cfg_rdata           = st_r.cfg;
   assign integ_mode          = st_r.integ;
   assign commute             = st_r.commute;
   assign falling_phase_limit = st_r.fall_thr;
   assign rising_phase_limit  = st_r.rise_thr;

   // Checks
   sequence s_zc_fast;
      ce && st_r.mode == CMS_ZERO_CROSSING && scnt_valid && scnt > su_lim;
   endsequence
   sequence s_zc_heavy;
      ce && st_r.mode == CMS_ZERO_CROSSING && duty_pct > du_lim;
   endsequence
   sequence s_int_slow;
      ce && st_r.mode != CMS_ZERO_CROSSING && scnt_valid && scnt < sl_lim;
   endsequence
   sequence s_int_light;
      ce && st_r.mode != CMS_ZERO_CROSSING && duty_pct < dl_lim;
   endsequence

   a_samples_enter: assert property (@(posedge clock) disable iff (!rst_int_n)
      s_zc_fast |=> integ_mode && st_r.mode == CMS_INTEG_WAIT) else $error("sample count did not enter integration");
   a_duty_exit: assert property (@(posedge clock) disable iff (!rst_int_n)
      s_int_light |=> !integ_mode) else $error("low duty did not leave integration");
   a_duty_enter: assert property (@(posedge clock) disable iff (!rst_int_n)
      s_zc_heavy |=> integ_mode) else $error("high duty did not enter integration");
   a_fall_code_max: assert property (@(posedge clock) disable iff (!rst_int_n)
      ce && st_r.cfg[16:11] == 6'h3F |=> falling_phase_limit == 12'hED8) else $error("falling limit 3Fh wrong");
   a_fall_code_seg: assert property (@(posedge clock) disable iff (!rst_int_n)
      ce && st_r.cfg[16:11] == 6'h31 |=> falling_phase_limit == 12'h6A4) else $error("falling limit 31h wrong");
   a_samples_exit: assert property (@(posedge clock) disable iff (!rst_int_n)
      s_int_slow |=> !integ_mode && st_r.acc == '0) else $error("low sample count did not leave integration");
   a_rise_code_seg: assert property (@(posedge clock) disable iff (!rst_int_n)
      ce && st_r.cfg[10:5] == 6'h20 |=> rising_phase_limit == 12'h320) else $error("rising limit 20h wrong");
   // A pulse caught by a low enable stands until the next enabled edge
   a_commute_once: assert property (@(posedge clock) disable iff (!rst_int_n)
      $rose(commute) |-> $past(st_r.mode) == CMS_INTEG_ACC && integ_mode) else $error("commute without accumulation");
   a_commute_pulse: assert property (@(posedge clock) disable iff (!rst_int_n)
      commute && ce |=> !commute) else $error("commute not a single pulse");

endmodule // cms_selector

// [logic/cms_defs.svh]
// Constants of the commutation method selector: register address,
// field positions, reset value and threshold encodings.
// Included by the selector module; definitions only.
`ifndef CMS_DEFS_SVH
`define CMS_DEFS_SVH

// Configuration register address and reset value
`define CMS_CFG3_ADDR      8'h8A
`define CMS_CFG3_RESET     32'h14000000

// Field positions inside the configuration word
`define CMS_SCNT_LO_HI     24
`define CMS_SCNT_LO_LO     23
`define CMS_SCNT_UP_HI     22
`define CMS_SCNT_UP_LO     21
`define CMS_DUTY_LO_HI     20
`define CMS_DUTY_LO_LO     19
`define CMS_DUTY_UP_HI     18
`define CMS_DUTY_UP_LO     17
`define CMS_FALL_HI        16
`define CMS_FALL_LO        11
`define CMS_RISE_HI        10
`define CMS_RISE_LO        5

// Samples per 30 degrees, upper switch codes 0..3
`define CMS_SU_0           8'h04
`define CMS_SU_1           8'h06
`define CMS_SU_2           8'h08
`define CMS_SU_3           8'h0A
// Samples per 30 degrees, lower switch codes 0..3
`define CMS_SL_0           8'h03
`define CMS_SL_1           8'h04
`define CMS_SL_2           8'h06
`define CMS_SL_3           8'h08
// Duty limits in whole percent, codes 0..3
`define CMS_DUTY_0         7'h0C
`define CMS_DUTY_1         7'h0F
`define CMS_DUTY_2         7'h12
`define CMS_DUTY_3         7'h14

// Back-EMF threshold decode: segment start codes, bases and steps
`define CMS_THR_SEG1       6'h20
`define CMS_THR_SEG2       6'h30
`define CMS_THR_SEG3       6'h38
`define CMS_THR_BASE1      12'h320
`define CMS_THR_BASE2      12'h640
`define CMS_THR_BASE3      12'h960
`define CMS_THR_STEP0      12'h019
`define CMS_THR_STEP1      12'h032
`define CMS_THR_STEP2      12'h064
`define CMS_THR_STEP3      12'h0C8

`endif

// [logic/cms_pkg.sv]
// Types shared by the commutation method selector.
// No assumptions beyond a SystemVerilog compiler.
package cms_pkg;

   // Commutation mode; Gray codes along zero-crossing, wait, accumulate
   typedef enum logic [1:0] {
      CMS_ZERO_CROSSING = 2'h0,
      CMS_INTEG_WAIT    = 2'h1,
      CMS_INTEG_ACC     = 2'h3
   } cms_mode_t;

endpackage

// [tb/cms_selector_bench.sv]
// Self-checking bench for the commutation method selector.
// Assumes the selector's defaults (12-bit back-EMF, 16-bit sum) and one clock.
`timescale 1ns/1ps

`define CHK(nm, ex, got) \
   begin \
      n_compared++; \
      if ((got) !== (ex)) \
      begin \
         failures++; \
         $display("mismatch %s expected %0h seen %0h", nm, ex, got); \
      end \
   end

module cms_selector_bench;
   import cms_pkg::*;

   // Stimulus and observed outputs
   logic        clock = 1'b0;
   logic        rst_n, ce, cfg_wr, scnt_valid, zero_point, phase_falling, bemf_valid;
   logic [7:0]  cfg_addr, scnt;
   logic [31:0] cfg_wdata, cfg_rdata;
   logic [6:0]  duty_pct;
   logic [11:0] bemf_mag, falling_phase_limit, rising_phase_limit;
   logic        integ_mode, commute;
   // Reference model state
   logic [31:0] m_cfg;
   logic        e_mode, e_com;
   int          acc, lim, failures, n_compared;
   int          fl, rl;
   bit          act;
   int          sl[4] = '{3, 4, 6, 8};
   int          dt[4] = '{12, 15, 18, 20};

   always #5 clock = ~clock;

   cms_selector u_cms_selector (.clock(clock), .rst_n(rst_n), .ce(ce), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .scnt_valid(scnt_valid), .scnt(scnt), .duty_pct(duty_pct),
      .zero_point(zero_point), .phase_falling(phase_falling), .bemf_valid(bemf_valid), .bemf_mag(bemf_mag),
      .integ_mode(integ_mode), .commute(commute), .falling_phase_limit(falling_phase_limit),
      .rising_phase_limit(rising_phase_limit));

   // Threshold decode in four segments of 25, 50, 100 and 200
   function automatic int thr(input int c);
      if (c <= 32) return c * 25;
      if (c <= 48) return 800 + (c - 32) * 50;
      if (c <= 56) return 1600 + (c - 48) * 100;
      return 2400 + (c - 56) * 200;
   endfunction

   // mode choice and integration, old config used at a write edge
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         m_cfg = 32'h14000000;
         e_mode = 1'b0; e_com = 1'b0; acc = 0; act = 1'b0;
         fl = 0;
         rl = 0;
      end
      else if (ce)
      begin
         e_com = 1'b0;
         // Decoded limits trail the stored word by one enabled edge
         lim = phase_falling ? fl : rl;
         if (!e_mode)
         begin
            if ((scnt_valid && scnt > 4 + 2 * m_cfg[22:21]) || duty_pct > dt[m_cfg[18:17]]) e_mode = 1'b1;
         end
         else if ((scnt_valid && scnt < sl[m_cfg[24:23]]) || duty_pct < dt[m_cfg[20:19]])
         begin
            e_mode = 1'b0; act = 1'b0;
         end
         else if (zero_point)
         begin
            acc = 0; act = 1'b1;
         end
         else if (act && bemf_valid)
         begin
            if (acc + bemf_mag >= lim)
            begin
               e_com = 1'b1; act = 1'b0;
            end
            else acc = (acc + bemf_mag > 65535) ? 65535 : acc + bemf_mag;
         end
         fl = thr(int'(m_cfg[16:11]));
         rl = thr(int'(m_cfg[10:5]));
         if (cfg_wr && cfg_addr === 8'h8A) m_cfg = cfg_wdata;
      end
   end

   // Compare each cycle, 1 ns after the falling edge so a reset dropped there has settled
   always @(negedge clock)
   begin
      #1;
      `CHK("cfg_rdata", m_cfg, cfg_rdata)
      `CHK("integ_mode", e_mode, integ_mode)
      `CHK("commute", e_com, commute)
      `CHK("falling_phase_limit", 12'(fl), falling_phase_limit)
      `CHK("rising_phase_limit", 12'(rl), rising_phase_limit)
   end

   // Neutral inputs: duty 12 percent never moves the mode out of zero-crossing
   task automatic idle(input int n);
      repeat (n)
      begin
         @(negedge clock);
         ce = 1'b1; cfg_wr = 1'b0; scnt_valid = 1'b0; zero_point = 1'b0; bemf_valid = 1'b0;
         duty_pct = 7'h0C;
      end
   endtask

   task automatic wr(input logic [31:0] w);
      @(negedge clock);
      cfg_wr = 1'b1; cfg_addr = 8'h8A; cfg_wdata = w;
      idle(3);
   endtask

   task automatic test_done;
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Watchdog sized well above the expected three thousand cycles
   initial
   begin
      #100000;
      failures++;
      test_done;
   end

   initial
   begin
      ce = 1'b1; cfg_wr = 1'b0; cfg_addr = 8'h00; cfg_wdata = 32'h0; scnt_valid = 1'b0; scnt = 8'h00;
      duty_pct = 7'h0C; zero_point = 1'b0; phase_falling = 1'b0; bemf_valid = 1'b0; bemf_mag = 12'h000;
      rst_n = 1'b0;
      void'($urandom(32'h672CC904));
      repeat (2) @(posedge clock);
      idle(1);
      rst_n = 1'b1;
      idle(3);
      // Every threshold code on both slopes, the rising one mirrored
      for (int c = 0; c < 64; c++)
      begin
         wr(32'h14000000 | (c << 11) | ((63 - c) << 5));
         `CHK("falling_phase_limit", 12'(thr(c)), falling_phase_limit)
         `CHK("rising_phase_limit", 12'(thr(63 - c)), rising_phase_limit)
      end
      $display("test threshold decode done");
      // Rounds of reset, random config, then random traffic with refused writes
      for (int r = 0; r < 16; r++)
      begin
         idle(1);
         rst_n = 1'b0;
         idle(2);
         rst_n = 1'b1;
         idle(3);
         wr($urandom);
         repeat (150)
         begin
            @(negedge clock);
            ce = ($urandom % 8) != 0;
            scnt_valid = ($urandom % 4) == 0;
            scnt = 8'($urandom % 16);
            duty_pct = 7'(8 + $urandom % 16);
            zero_point = ($urandom % 10) == 0;
            phase_falling = 1'($urandom);
            bemf_valid = 1'($urandom);
            bemf_mag = 12'($urandom % 1024);
            cfg_wr = ($urandom % 8) == 0;
            cfg_addr = ce ? 8'h8B : 8'h8A;
            cfg_wdata = $urandom;
         end
         idle(1);
      end
      $display("test random mode and integration done");
      test_done;
   end
endmodule // cms_selector_bench
